// ---- hw/cpc_map.svh ----
// Purpose: Register offsets, field positions and reset values of the clock control block.
// Assumes: Printed offsets are register indices; byte address is four times the index.
// Notes:   The 48-bit divider register occupies two consecutive words.
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH
`define CPC_IDX_CLK_CTRL     16'h4000
`define CPC_IDX_REG_LEVEL    16'h4001
`define CPC_IDX_PLL_CFG      16'h4002
`define CPC_ADDR_CLK_CTRL    32'h0001_0000
`define CPC_ADDR_REG_LEVEL   32'h0001_0004
`define CPC_ADDR_PLL_LO      32'h0001_0008
`define CPC_ADDR_PLL_HI      32'h0001_000c
`define CPC_RST_CLK_CTRL     8'h00
`define CPC_RST_REG_LEVEL    8'h02
`define CPC_RST_PLL_CFG      48'h0753_0287_1901
`define CPC_CLK_CTRL_MASK    8'h7f
`define CPC_REG_LEVEL_MASK   8'h06
`define CPC_PLL_WR_MASK      48'hffff_ffff_7f01
`define CPC_FLD_DEN_HI       47:40
`define CPC_FLD_DEN_LO       39:32
`define CPC_FLD_NUM_HI       31:24
`define CPC_FLD_NUM_LO       23:16
`define CPC_FLD_INT          14:11
`define CPC_FLD_IN_DIV       10:9
`define CPC_BIT_FRAC         8
`define CPC_BIT_LOCK         1
`define CPC_BIT_PLL_EN       0
`define CPC_MASTER_CLOCK_OUT_PIN_32          2'h0
`define CPC_MASTER_CLOCK_OUT_PIN_64          2'h1
`define CPC_MASTER_CLOCK_OUT_PIN_128         2'h2
`define CPC_MASTER_CLOCK_OUT_PIN_256         2'h3
`define CPC_IN_FREQ_PLL      2'h3
`define CPC_HTRANS_NONSEQ    2'h2
`define CPC_HTRANS_SEQ       2'h3
`endif

// ---- hw/cpc_pkg.sv ----
// Purpose: Types shared by the clock control block.
// Assumes: Field layouts follow the register map header.
// Notes:   Structs are packed so that they overlay the register words.
package cpc_pkg;
  typedef struct packed {
    logic       rsvd;
    logic [1:0] master_clock_out_pin_freq;
    logic       master_clock_out_pin_en;
    logic       src_pll;
    logic [1:0] in_freq;
    logic       core_en;
  } cpc_clk_ctrl_t;

  typedef struct packed {
    logic [15:0] den;
    logic [15:0] num;
    logic        rsvd15;
    logic [3:0]  int_ratio;
    logic [1:0]  in_div;
    logic        frac;
    logic [5:0]  rsvd2;
    logic        lock;
    logic        en;
  } cpc_pll_cfg_t;

  typedef enum logic [1:0] {
    CPC_GATE_OFF  = 2'b00,
    CPC_GATE_LOAD = 2'b01,
    CPC_GATE_RUN  = 2'b10
  } cpc_gate_t;
endpackage

// ---- hw/cpc_edge_div.sv ----
// Purpose: Divide a stream of clock edge pulses by 1 to 4.
// Assumes: Edge pulses are synchronous to core_clk_i.
// Notes:   Counter holds at zero while stopped so restarts begin on a whole period.
`timescale 1ns/1ps
module cpc_edge_div (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Source clock
  input  wire logic       edge_i,
  input  wire logic       level_i,
  input  wire logic [1:0] div_code_i,
  input  wire logic       run_i,
  // Divided clock
  output logic            tick_o,
  output logic            level_o
);
  logic [1:0] cnt_r;
  logic       wrap;
  logic       lvl_nxt;
  logic       armed_r;

  assign wrap    = (cnt_r == div_code_i);
  assign lvl_nxt = (div_code_i == 2'h0) ? level_i : (cnt_r <= {1'b0, div_code_i[1]});

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r   <= 2'h0;
      armed_r <= 1'b0;
      tick_o  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      tick_o  <= edge_i && wrap;
      // The level stays low until a whole period begins, so a start never makes a runt.
      level_o <= armed_r && lvl_nxt;
      if (edge_i && wrap) begin
        armed_r <= 1'b1;
      end
      if (edge_i) begin
        cnt_r <= wrap ? 2'h0 : cnt_r + 2'h1;
      end
    end
  end
endmodule

// ---- hw/cpc_frac_div.sv ----
// Purpose: Feedback divider dividing the PLL output by R plus N over M.
// Assumes: Integer ratio between 2 and 8, numerator below denominator.
// Notes:   A zero denominator falls back to plain integer division.
`timescale 1ns/1ps
module cpc_frac_div (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Settings
  input  wire logic        run_i,
  input  wire logic        frac_i,
  input  wire logic [3:0]  int_i,
  input  wire logic [15:0] num_i,
  input  wire logic [15:0] den_i,
  // PLL output edges
  input  wire logic        edge_i,
  // Feedback clock
  output logic             fb_tick_o,
  output logic             fb_level_o
);
  logic [3:0]  cnt_r;
  logic [4:0]  period_r;
  logic [15:0] acc_r;
  logic [16:0] acc_sum;
  logic        carry;
  logic        end_cnt;

  assign acc_sum = {1'b0, acc_r} + {1'b0, num_i};
  assign carry   = frac_i && (den_i != 16'h0) && (acc_sum >= {1'b0, den_i});
  assign end_cnt = ({1'b0, cnt_r} + 5'h1) >= period_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r      <= 4'h0;
      acc_r      <= 16'h0;
      period_r   <= {1'b0, int_i};
      fb_tick_o  <= 1'b0;
      fb_level_o <= 1'b0;
    end else begin
      fb_tick_o <= edge_i && end_cnt;
      if (edge_i) begin
        fb_level_o <= ({cnt_r, 1'b0} < period_r);
        if (end_cnt) begin
          cnt_r    <= 4'h0;
          acc_r    <= carry ? 16'(acc_sum - {1'b0, den_i}) : (frac_i ? acc_sum[15:0] : 16'h0);
          period_r <= {1'b0, int_i} + {4'h0, carry};
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule

// ---- hw/cpc_clock_ctrl.sv ----
// Purpose: Clock source selection, core clock division, master clock output and PLL settings.
// Assumes: AHB-Lite slave with zero wait states; clock pins are sampled by core_clk_i.
// Notes:   Generated clocks are registered levels; the core clock also comes with a one-cycle tick pulse.
//
// Summary of operation
// R1 - Output pin at 32/64/128/256 times fs.
// R2 - Output pin enable bit, clear after reset.
// R3 - Source bit picks input pin or PLL.
// R4 - PLL source needs input frequency code 11.
// R5 - Divide selected clock by 1 to 4.
// R6 - Bypassed input must match programmed ratio.
// R7 - Input clock at most 1024 times 48 kHz.
// R8 - Core enable gates core clock, clear after reset.
// R9 - Regulator level reads 1.4 V after init.
// R10 - 48-bit PLL register updates from whole burst.
// R11 - Denominator is bits 47:40 then 39:32.
// R12 - Numerator is bits 31:24 then 23:16.
// R13 - Integer ratio must be 2 to 8.
// R14 - Input divider scales clock before PLL.
// R15 - Bit 8 selects fractional or integer-N.
// R16 - Fractional feedback divides by R plus N/M.
// R17 - Integer multiples still use integer-N type.
// R18 - Lock bit read only and sticky.
// R19 - Bit 0 enables the PLL.
// R20 - Source and divider change without glitches.
// R21 - Wait for lock before core enable.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_clock_ctrl
  import cpc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Clock pins and analog PLL
  input  wire logic        master_clock_in_pin_i,
  input  wire logic        pll_clk_pin_i,
  input  wire logic        pll_lock_pin_i,
  output logic             master_clock_out_pin_o,
  output logic             pll_enable_o,
  output logic             pll_ref_clk_o,
  output logic             pll_fb_clk_o,
  // Core clock and regulator
  output logic             core_clk_o,
  output logic             core_clk_tick_o,
  output logic [1:0]       core_supply_output_level_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [2:0] mclk_sync_r;
  logic [2:0] pllc_sync_r;
  logic [1:0] lock_sync_r;
  logic       mclk_edge;
  logic       pllc_edge;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mclk_sync_r <= 3'h0;
      pllc_sync_r <= 3'h0;
      lock_sync_r <= 2'h0;
    end else begin
      mclk_sync_r <= {mclk_sync_r[1:0], master_clock_in_pin_i};
      pllc_sync_r <= {pllc_sync_r[1:0], pll_clk_pin_i};
      lock_sync_r <= {lock_sync_r[0], pll_lock_pin_i};
    end
  end

  // Edges are taken between the second and third stages only.
  assign mclk_edge = mclk_sync_r[1] && !mclk_sync_r[2];
  assign pllc_edge = pllc_sync_r[1] && !pllc_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  cpc_clk_ctrl_t clk_ctrl_r;
  logic [7:0]    reg_level_r;
  cpc_pll_cfg_t  pll_cfg_r;
  cpc_pll_cfg_t  pll_view;
  logic [31:0]   pll_stage_r;
  logic          pll_staged_r;
  logic          lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address and data phase.

  logic        dp_valid_r;
  logic        dp_write_r;
  logic [31:0] dp_addr_r;
  logic        ap_take;
  logic        ap_read;
  logic        wr_clk;
  logic        wr_lvl;
  logic        wr_pll_lo;
  logic        wr_pll_hi;
  logic [31:0] rd_mux;

  // Only whole-word accesses are meaningful; narrower ones still answer OKAY.
  assign ap_take = hsel_i && hready_i && (htrans_i == `CPC_HTRANS_NONSEQ || htrans_i == `CPC_HTRANS_SEQ);
  assign ap_read = ap_take && !hwrite_i;

  assign wr_clk    = dp_valid_r && dp_write_r && (dp_addr_r == `CPC_ADDR_CLK_CTRL);
  assign wr_lvl    = dp_valid_r && dp_write_r && (dp_addr_r == `CPC_ADDR_REG_LEVEL);
  assign wr_pll_lo = dp_valid_r && dp_write_r && (dp_addr_r == `CPC_ADDR_PLL_LO);
  assign wr_pll_hi = dp_valid_r && dp_write_r && (dp_addr_r == `CPC_ADDR_PLL_HI);

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 32'h0;
    end else if (hready_i) begin
      dp_valid_r <= ap_take;
      dp_write_r <= hwrite_i;
      dp_addr_r  <= {haddr_i[31:2], 2'b00};
    end
  end

  // Read data is registered at the address phase, so it stands during the data phase.
  assign rd_mux = (haddr_i[31:2] == `CPC_ADDR_CLK_CTRL >> 2) ? {24'h0, clk_ctrl_r} :
                  (haddr_i[31:2] == `CPC_ADDR_REG_LEVEL >> 2) ? {24'h0, reg_level_r} :
                  (haddr_i[31:2] == `CPC_ADDR_PLL_LO >> 2) ? pll_view[31:0] :
                  (haddr_i[31:2] == `CPC_ADDR_PLL_HI >> 2) ? {16'h0, pll_view[47:32]} :
                  32'h0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0;
    end else if (ap_read) begin
      hrdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock control and regulator registers.

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // R2 output off; R8 core gated
      clk_ctrl_r <= cpc_clk_ctrl_t'(`CPC_RST_CLK_CTRL);
      // R9 starts at 1.4 V
      reg_level_r <= `CPC_RST_REG_LEVEL;
    end else begin
      if (wr_clk) begin
        clk_ctrl_r <= cpc_clk_ctrl_t'(hwdata_i[7:0] & `CPC_CLK_CTRL_MASK);
      end
      if (wr_lvl) begin
        reg_level_r <= hwdata_i[7:0] & `CPC_REG_LEVEL_MASK;
      end
    end
  end

  assign core_supply_output_level_o = reg_level_r[2:1];

  ////////////////////////////////////////////////////////////////////////////
  // PLL divider register, loaded as one burst.

  logic [47:0] pll_new;
  logic        lock_clr;

  // R10 commit whole burst
  assign pll_new  = {hwdata_i[15:0], pll_stage_r} & `CPC_PLL_WR_MASK;
  assign lock_clr = wr_pll_hi && pll_staged_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pll_cfg_r    <= cpc_pll_cfg_t'(`CPC_RST_PLL_CFG);
      pll_stage_r  <= 32'h0;
      pll_staged_r <= 1'b0;
    end else begin
      if (wr_pll_lo) begin
        pll_stage_r  <= hwdata_i;
        pll_staged_r <= 1'b1;
      end else if (wr_pll_hi) begin
        pll_staged_r <= 1'b0;
        // R10 lone upper half ignored
        if (pll_staged_r) begin
          pll_cfg_r <= cpc_pll_cfg_t'({pll_new[47:2], 1'b0, pll_new[0]});
        end
      end else if (dp_valid_r && dp_write_r) begin
        pll_staged_r <= 1'b0;
      end
    end
  end

  // R18 sticky lock, set wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
    end else if (pll_cfg_r.en && lock_sync_r[1]) begin
      lock_r <= 1'b1;
    end else if (lock_clr || !pll_cfg_r.en) begin
      lock_r <= 1'b0;
    end
  end

  always_comb begin
    pll_view      = pll_cfg_r;
    pll_view.lock = lock_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL reference and feedback paths.

  logic        ref_tick;
  logic [15:0] pll_den;
  logic [15:0] pll_num;

  // R11 denominator bytes
  assign pll_den = {pll_cfg_r[`CPC_FLD_DEN_HI], pll_cfg_r[`CPC_FLD_DEN_LO]};
  // R12 numerator bytes
  assign pll_num = {pll_cfg_r[`CPC_FLD_NUM_HI], pll_cfg_r[`CPC_FLD_NUM_LO]};
  // R19 PLL enable
  assign pll_enable_o = pll_cfg_r.en;

  // R14 input divider ahead of PLL
  cpc_edge_div u_ref_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .edge_i     (mclk_edge),
    .level_i    (mclk_sync_r[2]),
    .div_code_i (pll_cfg_r.in_div),
    .run_i      (pll_cfg_r.en),
    .tick_o     (ref_tick),
    .level_o    (pll_ref_clk_o)
  );

  // R15 type bit; R16 divide by R plus N/M
  cpc_frac_div u_fb_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (pll_cfg_r.en),
    .frac_i     (pll_cfg_r.frac),
    .int_i      (pll_cfg_r.int_ratio),
    .num_i      (pll_num),
    .den_i      (pll_den),
    .edge_i     (pllc_edge),
    .fb_tick_o  (),
    .fb_level_o (pll_fb_clk_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core clock gating and source selection.

  cpc_gate_t  gate_r;
  cpc_gate_t  gate_nxt;
  logic       src_pll_r;
  logic [1:0] core_div_r;
  logic       src_edge;
  logic       src_level;
  logic       core_run;
  logic       core_live;

  // R20 settings move only while the core clock is stopped.
  always_comb begin
    gate_nxt = gate_r;
    case (gate_r)
      CPC_GATE_OFF: begin
        if (clk_ctrl_r.core_en && !core_clk_o) begin
          gate_nxt = CPC_GATE_LOAD;
        end
      end
      CPC_GATE_LOAD: begin
        gate_nxt = clk_ctrl_r.core_en ? CPC_GATE_RUN : CPC_GATE_OFF;
      end
      CPC_GATE_RUN: begin
        if (!clk_ctrl_r.core_en) begin
          gate_nxt = CPC_GATE_OFF;
        end
      end
      default: begin
        gate_nxt = CPC_GATE_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gate_r     <= CPC_GATE_OFF;
      src_pll_r  <= 1'b0;
      core_div_r <= 2'h0;
    end else begin
      gate_r <= gate_nxt;
      // R20 latch while gated
      if (gate_r != CPC_GATE_RUN && !core_clk_o) begin
        src_pll_r  <= clk_ctrl_r.src_pll;
        core_div_r <= clk_ctrl_r.in_freq;
      end
    end
  end

  // R3 source select
  assign src_edge  = src_pll_r ? pllc_edge : mclk_edge;
  assign src_level = src_pll_r ? pllc_sync_r[2] : mclk_sync_r[2];
  // R8 core clock gate
  assign core_run  = (gate_r == CPC_GATE_RUN);
  // A high phase always runs to its end; a source that stops while high holds the switch.
  assign core_live = core_run || core_clk_o;

  // R5 divide by 1 to 4
  cpc_edge_div u_core_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .edge_i     (src_edge),
    .level_i    (src_level),
    .div_code_i (core_div_r),
    .run_i      (core_live),
    .tick_o     (core_clk_tick_o),
    .level_o    (core_clk_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master clock output pin.

  logic [2:0] master_clock_out_pin_cnt_r;
  logic       master_clock_out_pin_nxt;

  // R1 frequency select; R2 output enable
  assign master_clock_out_pin_nxt = !clk_ctrl_r.master_clock_out_pin_en ? 1'b0 :
                    (clk_ctrl_r.master_clock_out_pin_freq == `CPC_MASTER_CLOCK_OUT_PIN_256) ? core_clk_o :
                    (clk_ctrl_r.master_clock_out_pin_freq == `CPC_MASTER_CLOCK_OUT_PIN_128) ? master_clock_out_pin_cnt_r[0] :
                    (clk_ctrl_r.master_clock_out_pin_freq == `CPC_MASTER_CLOCK_OUT_PIN_64) ? master_clock_out_pin_cnt_r[1] :
                    master_clock_out_pin_cnt_r[2];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      master_clock_out_pin_cnt_r             <= 3'h0;
      master_clock_out_pin_o <= 1'b0;
    end else begin
      master_clock_out_pin_o <= master_clock_out_pin_nxt;
      if (!core_run) begin
        master_clock_out_pin_cnt_r <= 3'h0;
      end else if (core_clk_tick_o) begin
        master_clock_out_pin_cnt_r <= master_clock_out_pin_cnt_r + 3'h1;
      end
    end
  end

  // The read path shows the sticky lock_r bit; the stored copy of that bit stays zero.
  logic unused_ok;
  assign unused_ok = ^{hsize_i, ref_tick};

endmodule

// ---- verif/cpc_clock_ctrl_sva.sv ----
// Purpose: Port checks for the clock control block.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Clock control writes are shadowed from the bus.
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_clock_ctrl_sva (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Clocks and regulator
  input wire logic        master_clock_out_pin_o,
  input wire logic        pll_enable_o,
  input wire logic        pll_ref_clk_o,
  input wire logic        pll_fb_clk_o,
  input wire logic        core_clk_o,
  input wire logic        core_clk_tick_o,
  input wire logic [1:0]  core_supply_output_level_o
);
  logic       wr_r;
  logic [7:0] ctrl_r;
  logic [5:0] quiet_r;
  ////////////////////////////////////////////////////////////
  // The quiet count lets glitch-free gating finish before outputs are judged.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_r    <= 1'b0;
      ctrl_r  <= `CPC_RST_CLK_CTRL;
      quiet_r <= 6'h3f;
    end else begin
      wr_r    <= hsel_i & hready_i & htrans_i[1] & hwrite_i & (haddr_i == `CPC_ADDR_CLK_CTRL);
      ctrl_r  <= wr_r ? hwdata_i[7:0] : ctrl_r;
      quiet_r <= wr_r ? 6'h00 : quiet_r + {5'h00, quiet_r != 6'h3f};
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  level_init_a: assert property ($fell(rst_i) |-> core_supply_output_level_o == 2'h1)
    else $error("regulator level not 1.4 V after reset");
  core_gate_a: assert property (quiet_r == 6'h3f && !ctrl_r[0] |-> !core_clk_o)
    else $error("core clock runs while disabled");
  master_clock_out_pin_off_a: assert property (quiet_r == 6'h3f && !ctrl_r[4] |-> !master_clock_out_pin_o)
    else $error("output clock pin active while disabled");
  master_clock_out_pin_full_a: assert property (ctrl_r[6:4] == 3'h7 && quiet_r > 6'h03 && $rose(master_clock_out_pin_o)
    |-> core_clk_o || $past(core_clk_o))
    else $error("full rate output pin not aligned to core clock");
  pll_off_a: assert property (!pll_enable_o [*4] |-> !pll_ref_clk_o && !pll_fb_clk_o)
    else $error("divider clocks run while pll disabled");
  tick_pulse_a: assert property (core_clk_tick_o |=> !core_clk_tick_o)
    else $error("core tick wider than one cycle");
  no_runt_a: assert property ($rose(core_clk_o) |=> core_clk_o)
    else $error("runt pulse on core clock");
  cover property ($rose(core_clk_o));
  cover property ($rose(master_clock_out_pin_o));
  cover property ($fell(pll_enable_o));
endmodule
bind cpc_clock_ctrl cpc_clock_ctrl_sva u_cpc_clock_ctrl_sva (
  .core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o,
  .hresp_o, .master_clock_out_pin_o, .pll_enable_o, .pll_ref_clk_o, .pll_fb_clk_o, .core_clk_o,
  .core_clk_tick_o, .core_supply_output_level_o);

// ---- verif/cpc_clock_ctrl_tb.sv ----
// Purpose: Self-checking bench for the clock control block.
// Assumes: Zero wait bus slave; clock pins slow against the bench clock.
// Notes:   Expected values come from a register model kept in the bench.
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_clock_ctrl_tb;
  localparam int MCK_H = 3;
  localparam int PLL_H = 2;
  localparam logic [31:0] LO = `CPC_ADDR_PLL_LO;
  localparam logic [31:0] HI = `CPC_ADDR_PLL_HI;
  localparam logic [31:0] CTL = `CPC_ADDR_CLK_CTRL;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        hsel_i     = 1'b0;
  logic [31:0] haddr_i    = 32'h0;
  logic [1:0]  htrans_i   = 2'h0;
  logic        hwrite_i   = 1'b0;
  logic [2:0]  hsize_i    = 3'h2;
  logic [31:0] hwdata_i   = 32'h0;
  logic        mck        = 1'b0;
  logic        pll_clk    = 1'b0;
  logic        lock_pin   = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, master_clock_out_pin, pll_en, ref_clk, fb_clk, core_clk;
  logic [1:0]  lvl;
  logic [3:0]  mon;
  int          miscompares = 0;
  int          compares    = 0;
  int          cycles      = 0;
  logic [31:0] seed        = 32'hd5c9f567;
  logic [7:0]  ctrl_m      = `CPC_RST_CLK_CTRL;
  logic [7:0]  lvl_m       = `CPC_RST_REG_LEVEL;
  logic [47:0] pll_m       = `CPC_RST_PLL_CFG;
  logic        lock_m      = 1'b0;
  logic        stg         = 1'b0;
  logic [31:0] stg_d;
  cpc_clock_ctrl u_cpc_clock_ctrl (
    .core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .master_clock_in_pin_i(mck), .pll_clk_pin_i(pll_clk), .pll_lock_pin_i(lock_pin),
    .master_clock_out_pin_o(master_clock_out_pin), .pll_enable_o(pll_en), .pll_ref_clk_o(ref_clk),
    .pll_fb_clk_o(fb_clk), .core_clk_o(core_clk), .core_clk_tick_o(), .core_supply_output_level_o(lvl));
  assign mon = {fb_clk, ref_clk, master_clock_out_pin, core_clk};
  ////////////////////////////////////////////////////////////
  always #2.5 core_clk_i = ~core_clk_i;
  always begin
    repeat (MCK_H) @(posedge core_clk_i);
    mck <= ~mck;
  end
  always begin
    repeat (PLL_H) @(posedge core_clk_i);
    pll_clk <= ~pll_clk;
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // The request is held until ready is seen, since a slave may stretch it.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel_i   <= 1'b1;
    htrans_i <= `CPC_HTRANS_NONSEQ;
    haddr_i  <= a;
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    if (a == CTL) ctrl_m = d[7:0] & `CPC_CLK_CTRL_MASK;
    if (a == `CPC_ADDR_REG_LEVEL) lvl_m = d[7:0] & `CPC_REG_LEVEL_MASK;
    if (a == HI && stg) begin
      pll_m  = {d[15:0], stg_d} & `CPC_PLL_WR_MASK;
      lock_m = 1'b0;
    end
    stg   = (a == LO);
    stg_d = d;
  endtask
  task automatic chk_all();
    logic [31:0] r;
    ahb(1'b0, CTL, 32'h0, r);
    chk_reg("clock_ctrl", {24'h0, ctrl_m}, r);
    ahb(1'b0, `CPC_ADDR_REG_LEVEL, 32'h0, r);
    chk_reg("reg_level", {24'h0, lvl_m}, r);
    ahb(1'b0, LO, 32'h0, r);
    chk_reg("pll_lo", pll_m[31:0] | {30'h0, lock_m, 1'b0}, r);
    ahb(1'b0, HI, 32'h0, r);
    chk_reg("pll_hi", {16'h0, pll_m[47:32]}, r);
    ahb(1'b0, 32'h0001_0010, 32'h0, r);
    chk_reg("unmapped", 32'h0, r);
    chk_reg("pll_enable", {31'h0, pll_m[0]}, {31'h0, pll_en});
    chk_reg("level_pin", {30'h0, lvl_m[2:1]}, {30'h0, lvl});
  endtask
  task automatic meas(input int s, input int n, output int c);
    logic p;
    int   e;
    c = 0;
    e = -1;
    while (e < n) begin
      p = mon[s];
      @(posedge core_clk_i);
      if (e >= 0) c++;
      if (mon[s] === 1'b1 && p === 1'b0) e++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r, q, lo, hi;
    int          c, n;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk_all();
    for (int i = 0; i < 8; i++) begin
      r  = rnd();
      q  = rnd();
      lo = {1'b0, r[30:15], 4'(2 + i % 7), r[10:0]};
      hi = {q[31:16], 1'b1, q[14:0]};
      wr(32'h0001_0010, q);
      wr(CTL, r | {29'h0, r[3], r[3], 1'b0});
      wr(`CPC_ADDR_REG_LEVEL, q);
      case (i % 4)
        0: begin wr(LO, lo); wr(HI, hi); end
        1: wr(HI, hi);
        2: begin wr(LO, lo); wr(CTL, r | {29'h0, r[3], r[3], 1'b0}); wr(HI, hi); end
        default: begin wr(LO, q); wr(LO, lo); wr(HI, hi); end
      endcase
      chk_all();
    end
    for (int d = 0; d < 4; d++) begin
      wr(CTL, {25'h0, d[1:0], 1'b1, 1'b0, d[1:0], 1'b0});
      wr(CTL, {25'h0, d[1:0], 1'b1, 1'b0, d[1:0], 1'b1});
      meas(0, 1, c);
      chk_cnt("core_period", 2 * MCK_H * (d + 1), c);
      meas(1, 1, c);
      chk_cnt("master_clock_out_pin_period", 2 * MCK_H * (d + 1) * (1 << (3 - d)), c);
    end
    wr(CTL, 32'h10);
    repeat (80) @(posedge core_clk_i);
    chk_reg("core_stopped", 32'h0, {31'h0, core_clk});
    wr(CTL, 32'h01);
    n = 0;
    repeat (100) begin
      @(posedge core_clk_i);
      n += int'(master_clock_out_pin === 1'b1);
    end
    chk_cnt("master_clock_out_pin_off_highs", 0, n);
    lock_pin <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(LO, {15'h0, k[0], 1'b0, 4'h3, k[1:0], k[0], 6'h0, 1'b0, 1'b1});
      wr(HI, 32'h0000_0002);
      // Dividers retuned while running need a few periods before their edges are regular.
      repeat (60) @(posedge core_clk_i);
      meas(2, 1, c);
      chk_cnt("ref_period", 2 * MCK_H * (k + 1), c);
      meas(3, 2, c);
      chk_cnt("fb_span", 2 * PLL_H * (12 + 2 * k[0]) / 2, c);
      n = 0;
      r = 32'h0;
      while (r[1] !== 1'b1 && n < 20) begin
        ahb(1'b0, LO, 32'h0, r);
        n++;
      end
      chk_reg("lock_set", 32'h1, {31'h0, r[1]});
    end
    lock_pin <= 1'b0;
    lock_m = 1'b1;
    repeat (10) @(posedge core_clk_i);
    chk_all();
    wr(CTL, 32'h0e);
    wr(CTL, 32'h0f);
    meas(0, 1, c);
    chk_cnt("pll_core_period", 2 * PLL_H * 4, c);
    wr(LO, 32'h0001_1f00);
    wr(HI, 32'h0000_0002);
    repeat (10) @(posedge core_clk_i);
    chk_all();
    stop_test();
  end
endmodule
